// File: common/hfa_defs.vh
// Constants for the half-flash converter host controller.
`ifndef HFA_DEFS_VH
`define HFA_DEFS_VH
// Register byte offsets on APB.
`define HFA_CTRL_OFS     12'h000
`define HFA_STAT_OFS     12'h004
`define HFA_RESULT_OFS   12'h008
`define HFA_IRQ_OFS      12'h00c
`define HFA_MASK_OFS     12'h010
// Control register fields.
`define HFA_CTRL_GO      0
`define HFA_CTRL_STYLE   1
`define HFA_CTRL_SUBB    2
`define HFA_CTRL_CH_LO   4
`define HFA_CTRL_CH_HI   6
// Status and interrupt bits.
`define HFA_STAT_BUSY    0
`define HFA_IRQ_DONE     0
`define HFA_IRQ_TMO      1
// Reset values.
`define HFA_CTRL_RST     8'h00
`define HFA_MASK_RST     2'h0
// Timing figures in ns and the clock period in ns.
`define HFA_CLK_NS       5
`define HFA_WR_PW_NS     250
`define HFA_WR_RD_NS     300
`define HFA_RD_PW_NS     150
`define HFA_ACC_NS       150
`define HFA_GAP_NS       100
`define HFA_RDB_PW_NS    70
`define HFA_CONV_RD_NS   1300
`define HFA_CONV_WR_NS   700
// Cycle counts; least times round up.
`define HFA_CYC_UP(ns)   (((ns) + `HFA_CLK_NS - 1) / `HFA_CLK_NS)
`endif

// File: verilog/hfa_host.v
// Host controller that drives a half-flash converter through its strobes.
//
// Contract
// - Channel code is binary input index
// - Read-start B: second read after done flag
// - Write-start A: read after done flag
// - Write-start B: read after 300 ns setup
// - Read-start A: select, read held low
// - Read hold time chooses read-start sub-mode
`timescale 1ns/10ps
`include "hfa_defs.vh"
module hfa_host #(
    parameter RD_TMO = 16'd2000     // Cycles allowed for done before giving up.
) (
    input  wire        pclk,        // APB clock.
    input  wire        presetn,     // Asynchronous reset, active low.
    input  wire        psel,        // APB select.
    input  wire        penable,     // APB enable.
    input  wire        pwrite,      // APB direction.
    input  wire [11:0] paddr,       // APB byte address.
    input  wire [31:0] pwdata,      // APB write data.
    output reg  [31:0] prdata,      // APB read data.
    output reg         pready,      // APB ready.
    output reg         pslverr,     // APB error for unmapped addresses.
    output reg         irq,         // Level interrupt.
    output reg         adc_sel_n,   // Device select, active low.
    output reg         adc_rd_n,    // Read strobe, active low.
    output reg         adc_wr_n,    // Convert strobe, active low.
    output reg         adc_style,   // Style pin: 0 read-start, 1 write-start.
    output reg  [2:0]  channel_pick,// Channel select code.
    input  wire        adc_done_n,  // Done flag from device, active low.
    input  wire        adc_wait_in, // Wait line level as seen on the wire.
    input  wire [7:0]  result_bus   // Result bus, bit 0 result_bus_lsb.
);
    // Least times in whole cycles, rounded up, then cut to the counter width on purpose.
    localparam integer WR_PW_N  = `HFA_CYC_UP(`HFA_WR_PW_NS);  // Convert strobe width.
    localparam integer WR_RD_N  = `HFA_CYC_UP(`HFA_WR_RD_NS);  // Convert-to-read setup.
    localparam integer RD_PW_N  = `HFA_CYC_UP(`HFA_RD_PW_NS);  // Read strobe width.
    localparam integer ACC_N    = `HFA_CYC_UP(`HFA_ACC_NS);    // Data access time.
    localparam integer GAP_N    = `HFA_CYC_UP(`HFA_GAP_NS);    // Wait between conversions.
    localparam integer RDB_PW_N = `HFA_CYC_UP(`HFA_RDB_PW_NS); // Short read pulse width.
    localparam [15:0]  WR_PW    = WR_PW_N[15:0];               // Convert strobe width.
    localparam [15:0]  WR_RD    = WR_RD_N[15:0];               // Convert-to-read setup.
    localparam [15:0]  RD_PW    = RD_PW_N[15:0];               // Read strobe width.
    localparam [15:0]  ACC      = ACC_N[15:0];                 // Data access time.
    localparam [15:0]  GAP      = GAP_N[15:0];                 // Wait between conversions.
    localparam [15:0]  RDB_PW   = RDB_PW_N[15:0];              // Short read pulse width.
    localparam [3:0] S_IDLE = 4'h0, S_SETUP = 4'h1, S_WRLO = 4'h2, S_WRHI = 4'h3,
                     S_WAITD = 4'h4, S_RDLO = 4'h5, S_GAP = 4'h6, S_RDWAIT = 4'h7,
                     S_BSHORT = 4'h8;
    reg  [3:0]  state;        // Sequencer state.
    reg  [15:0] cnt;          // Cycle counter for strobe timing.
    reg  [15:0] tmo;          // Timeout counter while awaiting done.
    reg  [7:0]  ctrl;         // Control register.
    reg  [7:0]  result;       // Last captured result.
    reg  [1:0]  irq_stat;     // Sticky events.
    reg  [1:0]  irq_mask;     // Event mask.
    reg         done_m, done_s, wait_m, wait_s; // Pin synchronisers.
    reg  [7:0]  data_m, data_s;                 // Result bus synchroniser.
    reg         ev_done, ev_tmo, go;            // One-cycle events and start.
    wire        acc    = psel & penable;
    wire        wr_acc = acc & pwrite;
    wire        mapped = (paddr == `HFA_CTRL_OFS) | (paddr == `HFA_STAT_OFS) |
                         (paddr == `HFA_RESULT_OFS) | (paddr == `HFA_IRQ_OFS) |
                         (paddr == `HFA_MASK_OFS);
    // Synchronise all device pins before the sequencer looks at them.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_m <= 1'b1;
            done_s <= 1'b1;
            wait_m <= 1'b1;
            wait_s <= 1'b1;
            data_m <= 8'h00;
            data_s <= 8'h00;
        end else begin
            done_m <= adc_done_n;
            done_s <= done_m;
            wait_m <= adc_wait_in;
            wait_s <= wait_m;
            data_m <= result_bus;
            data_s <= data_m;
        end
    end
    // APB slave: one wait-free cycle, writes at the access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata   <= 32'h0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            ctrl     <= `HFA_CTRL_RST;
            irq_mask <= `HFA_MASK_RST;
            irq_stat <= 2'h0;
            go       <= 1'b0;
            irq      <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            go      <= 1'b0;
            // Set wins over the write-one clear.
            irq_stat <= (irq_stat & ~((wr_acc && paddr == `HFA_IRQ_OFS && pready) ?
                        pwdata[1:0] : 2'h0)) | {ev_tmo, ev_done};
            irq <= |(irq_stat & irq_mask);
            if (wr_acc && pready) begin
                if (paddr == `HFA_CTRL_OFS) begin
                    ctrl <= pwdata[7:0];
                    go   <= pwdata[`HFA_CTRL_GO] & (state == S_IDLE);
                end
                if (paddr == `HFA_MASK_OFS) begin
                    irq_mask <= pwdata[1:0];
                end
            end
            if (psel && !penable) begin
                case (paddr)
                    `HFA_CTRL_OFS:   prdata <= {24'h0, ctrl & 8'hfe};
                    `HFA_STAT_OFS:   prdata <= {29'h0, ~wait_s, ~done_s, state != S_IDLE};
                    `HFA_RESULT_OFS: prdata <= {24'h0, result};
                    `HFA_IRQ_OFS:    prdata <= {30'h0, irq_stat};
                    `HFA_MASK_OFS:   prdata <= {30'h0, irq_mask};
                    default:         prdata <= 32'h0;
                endcase
            end
        end
    end
    // Strobe sequencer for both device styles.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= S_IDLE;
            cnt          <= 16'h0;
            tmo          <= 16'h0;
            adc_sel_n    <= 1'b1;
            adc_rd_n     <= 1'b1;
            adc_wr_n     <= 1'b1;
            adc_style    <= 1'b0;
            channel_pick <= 3'h0;
            result       <= 8'h00;
            ev_done      <= 1'b0;
            ev_tmo       <= 1'b0;
        end else begin
            ev_done <= 1'b0;
            ev_tmo  <= 1'b0;
            cnt     <= (cnt == 16'h0) ? 16'h0 : cnt - 16'h1;
            case (state)
                S_IDLE: begin
                    // The style pin follows the control bit only between transfers, so a
                    // control write during a conversion cannot flip the device's style.
                    adc_style <= ctrl[`HFA_CTRL_STYLE];
                    if (go) begin
                        channel_pick <= ctrl[`HFA_CTRL_CH_HI:`HFA_CTRL_CH_LO];
                        state        <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    adc_sel_n <= 1'b0;
                    tmo       <= RD_TMO;
                    if (adc_style) begin
                        adc_wr_n <= 1'b0;
                        cnt      <= WR_PW;
                        state    <= S_WRLO;
                    end else begin
                        adc_rd_n <= 1'b0;
                        cnt      <= ctrl[`HFA_CTRL_SUBB] ? RDB_PW : 16'h0;
                        state    <= ctrl[`HFA_CTRL_SUBB] ? S_BSHORT : S_RDWAIT;
                    end
                end
                S_WRLO: if (cnt == 16'h0) begin
                    adc_wr_n <= 1'b1;
                    cnt      <= WR_RD;
                    state    <= ctrl[`HFA_CTRL_SUBB] ? S_WRHI : S_WAITD;
                end
                S_WRHI: if (cnt == 16'h0) begin
                    adc_rd_n <= 1'b0;
                    cnt      <= ACC;
                    state    <= S_RDLO;
                end
                S_WAITD: begin
                    tmo <= tmo - 16'h1;
                    if (!done_s) begin
                        adc_rd_n <= 1'b0;
                        cnt      <= (ACC > RD_PW) ? ACC : RD_PW;
                        state    <= S_RDLO;
                    end else if (tmo == 16'h0) begin
                        ev_tmo <= 1'b1;
                        state  <= S_GAP;
                        adc_sel_n <= 1'b1;
                    end
                end
                S_BSHORT: if (cnt == 16'h0) begin
                    adc_rd_n <= 1'b1;
                    state    <= S_WAITD;
                end
                S_RDWAIT: begin
                    tmo <= tmo - 16'h1;
                    // Wait line high again means done fell and data is driven.
                    if (wait_s && !done_s) begin
                        cnt   <= ACC;
                        state <= S_RDLO;
                    end else if (tmo == 16'h0) begin
                        ev_tmo    <= 1'b1;
                        adc_rd_n  <= 1'b1;
                        adc_sel_n <= 1'b1;
                        state     <= S_GAP;
                    end
                end
                S_RDLO: if (cnt == 16'h0) begin
                    result    <= data_s;
                    ev_done   <= 1'b1;
                    adc_rd_n  <= 1'b1;
                    adc_sel_n <= 1'b1;
                    cnt       <= GAP;
                    state     <= S_GAP;
                end
                S_GAP: if (cnt == 16'h0) begin
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // hfa_host

// File: verification/hfa_host_sva.sv
// Checker of host strobe timing and APB answers.
`timescale 1ns/10ps
module hfa_host_sva (
    input wire       pclk,         // APB clock.
    input wire       presetn,      // Reset, active low.
    input wire       psel,         // APB select.
    input wire       penable,      // APB enable.
    input wire       pready,       // APB ready.
    input wire       adc_sel_n,    // Device select, active low.
    input wire       adc_rd_n,     // Read strobe, active low.
    input wire       adc_wr_n,     // Convert strobe, active low.
    input wire       adc_style,    // Style pin.
    input wire [2:0] channel_pick  // Channel code.
);
    reg [7:0] rd_lo; // Cycles with read low.
    reg [7:0] wr_hi; // Cycles with convert high.
    // Saturating phase counters.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_lo <= 8'h00;
            wr_hi <= 8'h00;
        end else begin
            rd_lo <= adc_rd_n ? 8'h00 : rd_lo + {7'h00, rd_lo != 8'hff};
            wr_hi <= !adc_wr_n ? 8'h00 : wr_hi + {7'h00, wr_hi != 8'hff};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rd_sel; !adc_rd_n |-> !adc_sel_n; endproperty
    a_rd_sel: assert property (p_rd_sel) else $error("read without select");
    property p_wr_sel; !adc_wr_n |-> !adc_sel_n; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("convert without select");
    property p_wr_sty; !adc_wr_n |-> adc_style; endproperty
    a_wr_sty: assert property (p_wr_sty) else $error("convert in read style");
    property p_setup; $fell(adc_rd_n) && adc_style |-> wr_hi >= 8'd60; endproperty
    a_setup: assert property (p_setup) else $error("read too soon");
    property p_rd_pw; $rose(adc_rd_n) && adc_style |-> rd_lo >= 8'd30; endproperty
    a_rd_pw: assert property (p_rd_pw) else $error("read pulse short");
    property p_rdb; $rose(adc_rd_n) && !adc_style |-> rd_lo >= 8'd14; endproperty
    a_rdb: assert property (p_rdb) else $error("read pulse short");
    property p_ch; !adc_sel_n |-> $stable(channel_pick); endproperty
    a_ch: assert property (p_ch) else $error("channel moved");
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready timing");
endmodule // hfa_host_sva
bind hfa_host hfa_host_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .adc_sel_n(adc_sel_n), .adc_rd_n(adc_rd_n),
    .adc_wr_n(adc_wr_n), .adc_style(adc_style), .channel_pick(channel_pick));

// File: verification/hfa_adc_model.sv
// Behavioural converter answering the host strobes.
`timescale 1ns/10ps
module hfa_adc_model (
    input  wire       pclk,   // Clock the model counts on.
    input  wire       sel_n,  // Device select, active low.
    input  wire       rd_n,   // Read strobe, active low.
    input  wire       wr_n,   // Convert strobe, active low.
    input  wire       style,  // Style pin.
    input  wire       mute,   // Mute stops completion.
    input  wire [2:0] ch,     // Channel code.
    output reg        done_n, // Done flag.
    output wire       wait_w, // Wait wire, pulled up.
    output wire [7:0] bus     // Result bus.
);
    reg [7:0] cnt, s, q; // Count, sample, result.
    reg       go_d, f_d, wlow; // Past terms, wait pull-down.
    wire go = !sel_n && (style ? !wr_n : !rd_n);
    wire fin = sel_n || rd_n; // Read or select high.
    initial {cnt, s, q, go_d, f_d, wlow, done_n} = {24'h0, 4'h5};
    // Sample at start; count 800 ns, or 400 ns after convert rises.
    always @(posedge pclk) begin
        go_d <= go;
        f_d <= fin;
        if (go && !go_d) s <= 8'ha0 | {5'h00, ch};
        if (go && !go_d) wlow <= !style;
        if (style ? (!go && go_d && !sel_n) : (go && !go_d)) cnt <= style ? 8'd80 : 8'd160;
        else if (cnt != 8'h00) cnt <= cnt - 8'd1;
        if (cnt == 8'd1 && !mute) begin
            done_n <= 1'b0;
            wlow <= 1'b0;
            q <= s;
        end else if (fin && !f_d) begin
            done_n <= 1'b1;
            wlow <= 1'b0;
        end
    end
    assign wait_w = !wlow;
    assign bus = (!sel_n && !rd_n && !done_n) ? q : ~q;
endmodule // hfa_adc_model

// File: verification/hfa_host_bench.sv
// Bench for the converter host controller.
`timescale 1ns/10ps
module hfa_host_bench;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mute = 0, mk = 0;
    reg  [11:0] paddr = 12'h000; // Address.
    reg  [31:0] pwdata = 32'h0, rd; // Write and read data.
    reg         sl; // Error answer.
    wire [31:0] prdata;
    wire        pready, pslverr, irq, adc_sel_n, adc_rd_n, adc_wr_n, adc_style;
    wire        adc_done_n, adc_wait_in;
    wire [2:0]  channel_pick;
    wire [7:0]  result_bus;
    integer     errors = 0, checks_done = 0, i, n, k;
    always #2.5 pclk = ~pclk;
    hfa_host #(.RD_TMO(16'd400)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .adc_sel_n(adc_sel_n), .adc_rd_n(adc_rd_n), .adc_wr_n(adc_wr_n),
        .adc_style(adc_style), .channel_pick(channel_pick), .adc_done_n(adc_done_n),
        .adc_wait_in(adc_wait_in), .result_bus(result_bus));
    hfa_adc_model adc (.pclk(pclk), .sel_n(adc_sel_n), .rd_n(adc_rd_n), .wr_n(adc_wr_n),
        .style(adc_style), .mute(mute), .ch(channel_pick), .done_n(adc_done_n),
        .wait_w(adc_wait_in), .bus(result_bus));
    // Report counts and end the run.
    task test_done;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Compare and count.
    task chk(input [32:0] got, input [32:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("unexpected at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer with a bounded wait for ready.
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            for (n = 0; n < 20 && pready !== 1'b1; n = n + 1) @(posedge pclk);
            if (n == 20) begin
                errors = errors + 1;
                test_done;
            end
            rd = prdata;
            sl = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // One conversion: start, poll, check result and interrupt, clear.
    task conv(input [2:0] c);
        begin
            apb(1, 12'h000, {25'h0, c, 1'b0, c[1], c[0], 1'b1});
            apb(0, 12'h004, 32'h0);
            chk(rd[0], 1'b1);
            apb(0, 12'h000, 32'h0);
            chk(rd, {25'h0, c, 1'b0, c[1], c[0], 1'b0});
            rd = 0;
            for (i = 0; i < 400 && rd[0] !== 1'b1; i = i + 1) apb(0, 12'h00c, 32'h0);
            if (i == 400) begin
                errors = errors + 1;
                test_done;
            end
            chk(rd[1:0], 2'b01);
            chk(irq, mk);
            apb(0, 12'h008, 32'h0);
            chk(rd[7:0], 8'ha0 | c);
            apb(1, 12'h00c, 32'h1);
            repeat (200) @(posedge pclk);
            chk(irq, 1'b0);
            // Idle again, with the wait line released.
            apb(0, 12'h004, 32'h0);
            chk({rd[2], rd[0]}, 2'b00);
        end
    endtask
    // Main sequence: reset values, unmapped place, every channel and mode, timeout.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        apb(0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(0, 12'h020, 32'h0);
        chk({sl, rd}, 33'h100000000);
        for (k = 0; k < 8; k = k + 1) begin
            conv(k[2:0]);
            mk = 1'b1;
            apb(1, 12'h010, 32'h3);
        end
        // Timeouts with a silent device: read-start wait, then write-start wait for done.
        mute <= 1'b1;
        for (k = 0; k < 2; k = k + 1) begin
            repeat (30) @(posedge pclk);
            apb(1, 12'h00c, 32'h3);
            apb(1, 12'h000, {30'h0, k[0], 1'b1});
            rd = 0;
            for (i = 0; i < 400 && rd[1] !== 1'b1; i = i + 1) apb(0, 12'h00c, 32'h0);
            if (i == 400) begin
                errors = errors + 1;
                test_done;
            end
            chk(rd[1:0], 2'b10);
            chk(irq, 1'b1);
        end
        test_done;
    end
endmodule // hfa_host_bench
